// >>> rtl/reset_pkg.sv
// Constants, register map and state codes for the reset source control block
// Behaviour
// RULE1 - Window field: 01=50%, 10=75%, 11=100%
// RULE2 - Erased watchdog option byte reads all ones
// RULE3 - Software programs watchdog option byte once
// RULE4 - Low reset pin holds pins, CPU, SFRs
// RULE5 - Pin rising starts fetch at reset vector
// RULE6 - Leaving reset selects low-speed oscillator, divide-by-one
// RULE7 - No reset clears RAM; mid-write corrupts it
// RULE8 - External source holds pin low 10 us
// RULE9 - At power-up pin low past stabilisation
// RULE10 - Supply above level 0: count 32, release
// RULE11 - Supply resets work only when enable bit 0
// RULE12 - Supply at or below level 0 resets
// RULE13 - Threshold and enable bits software read-only
// RULE14 - Watchdog select 1: underflow resets, restart
// RULE15 - Watchdog period and window from option byte
// RULE16 - Software request 1 resets and restarts
// RULE17 - Power-on and supply reset clear cold flag
// RULE18 - Software writing 1 sets warm start
// RULE19 - Pin, software, watchdog resets keep cold flag
// RULE20 - Each of three sources sets own flag
// RULE21 - Software writing 0 leaves cold flag
// RULE22 - Three detection flags are read-only
// RULE23 - Supply drop during count restarts count
// RULE24 - Reset pin synchronised before use
package reset_pkg;

  // ****************************************************************
  // Register map, byte addresses on the plain register port
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE0 = 8'h00;
  localparam logic [7:0] ADDR_MODE1 = 8'h01;
  localparam logic [7:0] ADDR_SOURCE = 8'h02;
  localparam logic [7:0] ADDR_WDOG_OPT = 8'h03;
  localparam logic [7:0] ADDR_START_OPT = 8'h04;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SOFT_RESET_BIT = 3;
  localparam int WDOG_SEL_BIT = 2;
  localparam int COLD_WARM_BIT = 0;
  localparam int PIN_FLAG_BIT = 1;
  localparam int SOFT_FLAG_BIT = 2;
  localparam int WDOG_FLAG_BIT = 3;
  localparam int MON_EN_N_BIT = 6;
  localparam int THRESHOLD_LO_BIT = 4;
  localparam int UNDERFLOW_LO_BIT = 0;
  localparam int WINDOW_LO_BIT = 2;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] WDOG_OPT_RESERVED = 8'hf0;
  localparam logic [1:0] WINDOW_25 = 2'h0;
  localparam logic [1:0] WINDOW_50 = 2'h1;
  localparam logic [1:0] WINDOW_75 = 2'h2;
  localparam logic [6:0] PERCENT_25 = 7'h19;
  localparam logic [6:0] PERCENT_50 = 7'h32;
  localparam logic [6:0] PERCENT_75 = 7'h4b;
  localparam logic [6:0] PERCENT_100 = 7'h64;
  localparam logic [2:0] CLOCK_DIV_ONE = 3'h0;

  // ****************************************************************
  // Timing counts, in clock cycles
  // ****************************************************************
  localparam int RELEASE_COUNT = 32;
  localparam logic [2:0] PULSE_CYCLES = 3'h4;

  // Reset sequencer states
  typedef enum logic [3:0] {
    ST_COUNT = 4'h1,
    ST_RUN = 4'h2,
    ST_PIN = 4'h4,
    ST_PULSE = 4'h8
  } seq_state_t;

endpackage : reset_pkg

// >>> rtl/reset_seq_if.sv
// Handshake between the reset sequencer and its release counter
`timescale 1ns/1ps
interface reset_seq_if;
  logic count_enable;
  logic count_clear;
  logic count_done;

  modport sequencer (
    output count_enable,
    output count_clear,
    input count_done
  );

  modport counter (
    input count_enable,
    input count_clear,
    output count_done
  );
endinterface : reset_seq_if

// >>> rtl/release_counter.sv
// Release counter that times the internal reset release after supply rise
`timescale 1ns/1ps
module release_counter
  import reset_pkg::*;
#(
  parameter int COUNT = RELEASE_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  reset_seq_if.counter link
);

  localparam int WIDTH = $clog2(COUNT + 1);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT - 1);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic done;
  } counter_state_t;

  counter_state_t s;
  counter_state_t next_s;

  // Count only while enabled; a clear always restarts from zero
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (link.count_clear) begin
      next_s.count = '0; // see RULE23
    end else if (link.count_enable) begin
      if (s.count == LAST) begin
        next_s.done = 1'b1; // see RULE10
        next_s.count = '0;
      end else begin
        next_s.count = s.count + WIDTH'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.count_done = s.done;

endmodule : release_counter

// >>> rtl/mcu_reset_source_control.sv
// Reset source combiner, sequencer and reporting registers
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module mcu_reset_source_control
  import reset_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic supply_above_level0,
  input wire logic watchdog_underflow,
  input wire logic ram_write_active,
  input wire logic [7:0] startup_option_byte,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  output logic system_reset,
  output logic cpu_clock_low_speed,
  output logic [2:0] cpu_clock_divider,
  output logic fetch_reset_vector,
  output logic ram_contents_undefined,
  output logic [1:0] underflow_period_sel,
  output logic [6:0] refresh_window_percent,
  output logic [1:0] threshold0_sel
);

  // ****************************************************************
  // State of the block
  // ****************************************************************
  // Synchronisers, sequencer, option byte and flags all live here;
  // one register process keeps reset handling in one place
  typedef struct packed {
    seq_state_t state;
    logic pin_s1;
    logic pin_s2;
    logic sup_s1;
    logic sup_s2;
    logic watchdog_reset_select;
    logic [7:0] watchdog_option_byte;
    logic option_written;
    logic cold_warm_flag;
    logic pin_reset_flag;
    logic soft_reset_flag;
    logic watchdog_reset_flag;
    logic [2:0] pulse_count;
    logic [7:0] read_data;
    logic fetch;
    logic ram_undefined;
    logic [6:0] window_percent;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  // Release counter handshake; the counter only counts, the
  // sequencer decides what a finished count means
  reset_seq_if link ();

  // ****************************************************************
  // Decoded conditions
  // ****************************************************************
  // Combinational helpers, all on the block clock
  logic monitor_on;
  logic supply_low;
  logic in_run;
  logic write_mode0;
  logic write_mode1;
  logic write_source;
  logic write_wdog_opt;
  logic soft_request;
  logic wdog_request;
  logic [7:0] source_value;
  logic [7:0] mode1_value;

  // Supply resets only act with the enable-after-reset bit at zero
  assign monitor_on = ~startup_option_byte[MON_EN_N_BIT]; // see RULE11
  assign supply_low = monitor_on & ~s.sup_s2; // see RULE12
  assign in_run = (s.state == ST_RUN);

  // Register writes are only honoured while the CPU is running
  assign write_mode0 = write_strobe & in_run & (address == ADDR_MODE0);
  assign write_mode1 = write_strobe & in_run & (address == ADDR_MODE1);
  assign write_source = write_strobe & in_run & (address == ADDR_SOURCE);
  assign write_wdog_opt = write_strobe & in_run & (address == ADDR_WDOG_OPT);

  // Reset requests from software and from the watchdog
  assign soft_request = write_mode0 & write_data[SOFT_RESET_BIT]; // see RULE16
  assign wdog_request = watchdog_underflow & s.watchdog_reset_select; // see RULE14

  // Readback images of the source and mode registers
  always_comb begin
    source_value = 8'h00;
    source_value[COLD_WARM_BIT] = s.cold_warm_flag;
    source_value[PIN_FLAG_BIT] = s.pin_reset_flag;
    source_value[SOFT_FLAG_BIT] = s.soft_reset_flag;
    source_value[WDOG_FLAG_BIT] = s.watchdog_reset_flag;
    mode1_value = 8'h00;
    mode1_value[WDOG_SEL_BIT] = s.watchdog_reset_select;
  end

  // Counter runs only in the count state and only while supply_low is clear
  assign link.count_enable = (s.state == ST_COUNT) & ~supply_low;
  assign link.count_clear = (s.state != ST_COUNT) | supply_low; // see RULE23

  // Count length comes from the package constant
  release_counter #(
    .COUNT(RELEASE_COUNT)
  ) u_release_counter (
    .clock(clock),
    .reset(reset),
    .link(link)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s = s;
    // Pulse outputs default low every cycle
    next_s.fetch = 1'b0;
    next_s.ram_undefined = 1'b0;
    next_s.read_data = 8'h00;

    // Two-stage synchronisers; only the second stage is looked at
    next_s.pin_s1 = reset_pin_n; // see RULE24
    next_s.pin_s2 = s.pin_s1;
    next_s.sup_s1 = supply_above_level0;
    next_s.sup_s2 = s.sup_s1;

    // Sequencer: the CPU executes only in RUN. PIN waits for the
    // synchronised pin, PULSE times a software or watchdog reset,
    // COUNT times the release after power-on or a supply event.
    case (s.state)
      ST_RUN: begin
        // Priority: pin, then software, then watchdog
        if (~s.pin_s2) begin
          next_s.state = ST_PIN; // see RULE4
          next_s.pin_reset_flag = 1'b1; // see RULE20
        end else if (soft_request) begin
          next_s.state = ST_PULSE;
          next_s.pulse_count = PULSE_CYCLES;
          next_s.soft_reset_flag = 1'b1; // see RULE20
        end else if (wdog_request) begin
          next_s.state = ST_PULSE;
          next_s.pulse_count = PULSE_CYCLES;
          next_s.watchdog_reset_flag = 1'b1; // see RULE20
        end
      end
      ST_COUNT: begin
        // Pin held low at power-up takes over once the count ends
        if (link.count_done) begin
          if (~s.pin_s2) begin
            next_s.state = ST_PIN;
            next_s.pin_reset_flag = 1'b1;
          end else begin
            next_s.state = ST_RUN; // see RULE10
            next_s.fetch = 1'b1;
          end
        end
      end
      ST_PIN: begin
        // Release waits for the second synchroniser stage to go high
        if (s.pin_s2) begin
          next_s.state = ST_RUN; // see RULE5
          next_s.fetch = 1'b1;
        end
      end
      ST_PULSE: begin
        // A pin held low across the pulse hands over to the pin state,
        // so the CPU never runs for one cycle between two resets
        if ((s.pulse_count == 3'h1) & ~s.pin_s2) begin
          next_s.state = ST_PIN; // see RULE4
          next_s.pin_reset_flag = 1'b1; // see RULE20
          next_s.pulse_count = 3'h0;
        end else if (s.pulse_count == 3'h1) begin
          next_s.state = ST_RUN;
          next_s.fetch = 1'b1; // see RULE16
          next_s.pulse_count = 3'h0;
        end else begin
          next_s.pulse_count = s.pulse_count - 3'h1;
        end
      end
      default: begin
        next_s.state = ST_COUNT;
      end
    endcase

    // Supply drop wins over every other source, from any state
    // A dip mid-count restarts the full release wait
    if (supply_low) begin
      next_s.state = ST_COUNT; // see RULE12
      next_s.pulse_count = 3'h0;
    end

    // Cold flag: set by software only, cleared by power-on or supply reset
    if (write_source & write_data[COLD_WARM_BIT]) begin
      next_s.cold_warm_flag = 1'b1; // see RULE18
    end
    // Writing 0 has no effect; source flags ignore writes entirely
    // see RULE21
    // see RULE22
    if (supply_low) begin
      next_s.cold_warm_flag = 1'b0; // see RULE17
    end
    // Pin, software and watchdog resets never touch the cold flag
    // see RULE19

    // Watchdog reset select is an ordinary mode bit
    if (write_mode1) begin
      next_s.watchdog_reset_select = write_data[WDOG_SEL_BIT];
    end

    // Option byte: first software write sticks, later ones dropped
    // Reserved upper bits are forced to one, as in an erased byte
    if (write_wdog_opt & ~s.option_written) begin
      next_s.watchdog_option_byte = write_data | WDOG_OPT_RESERVED;
      next_s.option_written = 1'b1; // see RULE3
    end

    // Any reset returns the mode bits to their reset values
    if (next_s.state != ST_RUN) begin
      next_s.watchdog_reset_select = 1'b0;
    end

    // RAM is never cleared; flag a reset landing on a RAM write
    if (in_run & (next_s.state != ST_RUN) & ram_write_active) begin
      next_s.ram_undefined = 1'b1; // see RULE7
    end

    // Refresh window fraction decoded from the option byte
    case (s.watchdog_option_byte[WINDOW_LO_BIT +: 2])
      WINDOW_25: next_s.window_percent = PERCENT_25;
      WINDOW_50: next_s.window_percent = PERCENT_50; // see RULE1
      WINDOW_75: next_s.window_percent = PERCENT_75; // see RULE1
      default: next_s.window_percent = PERCENT_100; // see RULE1
    endcase

    // Read data stands only in the cycle after the strobe
    // Mode register 0 reads zero; its request bit is only a strobe
    if (read_strobe) begin
      case (address)
        ADDR_MODE0: next_s.read_data = 8'h00;
        ADDR_MODE1: next_s.read_data = mode1_value;
        ADDR_SOURCE: next_s.read_data = source_value;
        ADDR_WDOG_OPT: next_s.read_data = s.watchdog_option_byte;
        ADDR_START_OPT: next_s.read_data = startup_option_byte; // see RULE13
        default: next_s.read_data = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on: erased option byte, cold start, count before release
  always_ff @(posedge clock) begin
    if (reset) begin
      s.state <= ST_COUNT;
      s.pin_s1 <= 1'b0;
      s.pin_s2 <= 1'b0;
      s.sup_s1 <= 1'b0;
      s.sup_s2 <= 1'b0;
      s.watchdog_reset_select <= 1'b0;
      s.watchdog_option_byte <= ERASED_BYTE; // see RULE2
      s.option_written <= 1'b0;
      s.cold_warm_flag <= 1'b0; // see RULE17
      s.pin_reset_flag <= 1'b0;
      s.soft_reset_flag <= 1'b0;
      s.watchdog_reset_flag <= 1'b0;
      s.pulse_count <= 3'h0;
      s.read_data <= 8'h00;
      s.fetch <= 1'b0;
      s.ram_undefined <= 1'b0;
      s.window_percent <= PERCENT_100;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Everything here comes from flops except the constant clock outputs and threshold0_sel
  assign read_data = s.read_data;
  assign system_reset = (s.state != ST_RUN); // see RULE4
  assign fetch_reset_vector = s.fetch;
  assign ram_contents_undefined = s.ram_undefined;

  // Clock selection is fixed after every reset; later changes belong
  // to the clock controller, so these stay constant here
  assign cpu_clock_low_speed = 1'b1; // see RULE6
  assign cpu_clock_divider = CLOCK_DIV_ONE; // see RULE6

  // Watchdog setup taken from the option byte fields
  assign underflow_period_sel =
    s.watchdog_option_byte[UNDERFLOW_LO_BIT +: 2]; // see RULE15
  assign refresh_window_percent = s.window_percent; // see RULE15
  // Threshold select only passes through to the analog detector
  assign threshold0_sel = startup_option_byte[THRESHOLD_LO_BIT +: 2];

endmodule : mcu_reset_source_control

// >>> test/reset_circuit_model.sv
// External reset circuit and supply detector model for the reset block
`timescale 1ns/1ps
module reset_circuit_model #(
  parameter int LOW_CYCLES = 2500
) (
  input wire logic clock,
  input wire logic pin_go,
  input wire logic supply_go,
  output logic reset_pin_n,
  output logic supply_above_level0
);
  // ********
  // Hold counters
  // ********
  // Pin starts low over the supply rise, then 10 us more
  int pin_cnt = LOW_CYCLES + 8;
  int sup_cnt = 8;
  // Pin held low 10 us per request; pulled up when released
  always @(posedge clock) begin
    if (pin_go) begin
      pin_cnt <= LOW_CYCLES;
    end else if (pin_cnt > 0) begin
      pin_cnt <= pin_cnt - 1;
    end
    if (supply_go) begin
      sup_cnt <= 30;
    end else if (sup_cnt > 0) begin
      sup_cnt <= sup_cnt - 1;
    end
  end
  assign reset_pin_n = (pin_cnt == 0);
  // Two dips; the second lands inside the release count
  assign supply_above_level0 = !(sup_cnt > 22 || (sup_cnt > 0 && sup_cnt < 9));
endmodule : reset_circuit_model

// >>> test/reset_ctl_sva.sv
// Port-level properties of the reset source control block
`timescale 1ns/1ps
module reset_ctl_sva
  import reset_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic supply_above_level0,
  input wire logic watchdog_underflow,
  input wire logic ram_write_active,
  input wire logic [7:0] startup_option_byte,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] read_data,
  input wire logic system_reset,
  input wire logic cpu_clock_low_speed,
  input wire logic [2:0] cpu_clock_divider,
  input wire logic fetch_reset_vector,
  input wire logic ram_contents_undefined,
  input wire logic [1:0] underflow_period_sel,
  input wire logic [6:0] refresh_window_percent,
  input wire logic [1:0] threshold0_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] wopt;
  logic locked;
  logic wsel;
  logic [7:0] since_low;
  logic mon_low;
  assign mon_low = !supply_above_level0 && !startup_option_byte[MON_EN_N_BIT];
  // ********
  // Shadows: write-once byte, select, time since supply low
  // ********
  always_ff @(posedge clock) begin
    if (reset) begin
      wopt <= ERASED_BYTE;
      locked <= 1'b0;
      wsel <= 1'b0;
    end else begin
      if (write_strobe && !system_reset && !locked &&
          address == ADDR_WDOG_OPT) begin
        wopt <= write_data | WDOG_OPT_RESERVED;
        locked <= 1'b1;
      end
      if (system_reset) begin
        wsel <= 1'b0;
      end else if (write_strobe && address == ADDR_MODE1) begin
        wsel <= write_data[WDOG_SEL_BIT];
      end
    end
  end
  // Saturates so a long run never wraps back below the bound
  always_ff @(posedge clock) begin
    if (reset || mon_low) begin
      since_low <= 8'h00;
    end else if (since_low != 8'hff) begin
      since_low <= since_low + 8'h01;
    end
  end
  a_clock_default: assert property (
    cpu_clock_low_speed && cpu_clock_divider == CLOCK_DIV_ONE)
    else $error("cpu clock not low speed undivided");
  a_fetch_release: assert property (
    $fell(system_reset) |-> fetch_reset_vector ##1 !fetch_reset_vector)
    else $error("no single fetch pulse at release");
  a_pin_hold: assert property (
    !reset_pin_n [*5] |-> system_reset)
    else $error("low pin not holding reset");
  a_soft_pulse: assert property (
    write_strobe && address == ADDR_MODE0 && !system_reset &&
    write_data[SOFT_RESET_BIT] |=> system_reset [*4])
    else $error("software request did not reset");
  a_watchdog_reset: assert property (
    watchdog_underflow && wsel && !system_reset |=> system_reset)
    else $error("selected underflow did not reset");
  a_period_sel: assert property (
    underflow_period_sel == wopt[1:0])
    else $error("underflow period differs from option byte");
  a_window_map: assert property (
    refresh_window_percent == ($past(wopt[3:2]) == WINDOW_25 ? PERCENT_25 :
    $past(wopt[3:2]) == WINDOW_50 ? PERCENT_50 :
    $past(wopt[3:2]) == WINDOW_75 ? PERCENT_75 : PERCENT_100))
    else $error("refresh window percent wrong");
  a_threshold_pass: assert property (
    threshold0_sel == startup_option_byte[5:4])
    else $error("threshold select not from startup byte");
  a_supply_reset: assert property (
    mon_low [*5] |-> system_reset)
    else $error("low supply not holding reset");
  a_release_count: assert property (
    $fell(system_reset) |-> since_low >= 8'h20)
    else $error("reset released before 32 cycles of good supply");
  a_ram_undefined: assert property (
    ram_contents_undefined ==
    ($rose(system_reset) && $past(ram_write_active)))
    else $error("ram undefined flag wrong at reset entry");
endmodule : reset_ctl_sva

bind mcu_reset_source_control reset_ctl_sva u_sva (
  .clock(clock), .reset(reset), .reset_pin_n(reset_pin_n),
  .supply_above_level0(supply_above_level0), .address(address),
  .watchdog_underflow(watchdog_underflow), .write_data(write_data),
  .ram_write_active(ram_write_active), .write_strobe(write_strobe),
  .startup_option_byte(startup_option_byte), .read_strobe(read_strobe),
  .read_data(read_data), .system_reset(system_reset),
  .cpu_clock_low_speed(cpu_clock_low_speed),
  .cpu_clock_divider(cpu_clock_divider),
  .fetch_reset_vector(fetch_reset_vector),
  .ram_contents_undefined(ram_contents_undefined),
  .underflow_period_sel(underflow_period_sel),
  .refresh_window_percent(refresh_window_percent),
  .threshold0_sel(threshold0_sel)
);

// >>> test/testbench.sv
// Self-checking bench for the reset source control block
`timescale 1ns/1ps
module testbench;
  import reset_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic watchdog_underflow = 1'b0;
  logic ram_write_active = 1'b0;
  logic [7:0] startup_option_byte = 8'h8f;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic pin_go = 1'b0;
  logic supply_go = 1'b0;
  logic reset_pin_n, supply_above_level0, system_reset, fetch_reset_vector;
  logic [7:0] read_data;
  logic [1:0] underflow_period_sel;
  logic [6:0] refresh_window_percent;
  logic [6:0] pct_tab [4] = '{PERCENT_25, PERCENT_50, PERCENT_75, PERCENT_100};
  logic [31:0] r;
  integer seed = 32'hbdb0fb87;
  int failures = 0;
  int samples_checked = 0;
  // Source register model; power-up pin hold sets pin flag
  int cold = 0, pin_f = 1, soft_f = 0, wdog_f = 0;

  always #2 clock = ~clock;
  // RAM write activity wanders so reset entry sees both levels
  always @(posedge clock) ram_write_active <= 1'($random(seed));

  mcu_reset_source_control DUT (.clock(clock), .reset(reset),
    .reset_pin_n(reset_pin_n), .supply_above_level0(supply_above_level0),
    .watchdog_underflow(watchdog_underflow), .address(address),
    .ram_write_active(ram_write_active), .write_data(write_data),
    .startup_option_byte(startup_option_byte), .read_data(read_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .system_reset(system_reset), .cpu_clock_low_speed(),
    .cpu_clock_divider(), .fetch_reset_vector(fetch_reset_vector),
    .ram_contents_undefined(), .underflow_period_sel(underflow_period_sel),
    .refresh_window_percent(refresh_window_percent), .threshold0_sel());
  reset_circuit_model partner (.clock(clock), .pin_go(pin_go),
    .supply_go(supply_go), .reset_pin_n(reset_pin_n),
    .supply_above_level0(supply_above_level0));

  // ********
  // Shared tasks
  // ********
  function automatic logic [7:0] src();
    src = {4'h0, wdog_f[0], soft_f[0], pin_f[0], cold[0]};
  endfunction : src
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    check8(read_data, exp);
  endtask : rd
  task automatic kick(input int which);
    @(posedge clock);
    watchdog_underflow <= (which == 0);
    pin_go <= (which == 1);
    supply_go <= (which == 2);
    @(posedge clock);
    {watchdog_underflow, pin_go, supply_go} <= 3'b000;
  endtask : kick
  // Bounded waits for reset entry, then for release
  task automatic wait_run();
    int n;
    n = 0;
    #1;
    while (system_reset !== 1'b1 && n < 16) begin
      @(posedge clock);
      #1;
      n++;
    end
    n = 0;
    while (system_reset !== 1'b0 && n < 4000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check8({7'h00, system_reset}, 8'h00);
    check8({7'h00, fetch_reset_vector}, 8'h01);
  endtask : wait_run
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    #80000;
    failures++;
    finish_test();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    r = $random(seed);
    startup_option_byte = {2'b10, r[1:0], 4'hf};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    wait_run();
    rd(ADDR_SOURCE, src());
    wr(ADDR_START_OPT, 8'h00);
    rd(ADDR_START_OPT, startup_option_byte);
    rd(ADDR_WDOG_OPT, ERASED_BYTE);
    rd(8'h7f, 8'h00);
    wr(ADDR_SOURCE, 8'h00);
    rd(ADDR_SOURCE, src());
    wr(ADDR_SOURCE, 8'hff);
    cold = 1;
    rd(ADDR_SOURCE, src());
    wr(ADDR_MODE0, 8'h08);
    soft_f = 1;
    wait_run();
    rd(ADDR_SOURCE, src());
    wr(ADDR_MODE1, 8'h04);
    kick(0);
    wdog_f = 1;
    wait_run();
    rd(ADDR_SOURCE, src());
    kick(0);
    repeat (4) @(posedge clock);
    #1;
    check8({7'h00, system_reset}, 8'h00);
    kick(1);
    pin_f = 1;
    wait_run();
    rd(ADDR_SOURCE, src());
    kick(2);
    cold = 0;
    wait_run();
    rd(ADDR_SOURCE, src());
    // Fresh power-on per window code, since the byte takes one write
    for (int c = 0; c < 4; c++) begin
      @(posedge clock);
      reset <= 1'b1;
      startup_option_byte[MON_EN_N_BIT] <= c[1];
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      wait_run();
      rd(ADDR_SOURCE, 8'h00);
      r = $random(seed);
      wr(ADDR_WDOG_OPT, {r[7:4], c[1:0], r[1:0]});
      wr(ADDR_WDOG_OPT, ~{r[7:4], c[1:0], r[1:0]});
      rd(ADDR_WDOG_OPT, {4'hf, c[1:0], r[1:0]});
      check8({6'h00, underflow_period_sel}, {6'h00, r[1:0]});
      check8({1'b0, refresh_window_percent}, {1'b0, pct_tab[c]});
      // Supply dip resets only with the monitor enabled
      kick(2);
      repeat (12) @(posedge clock);
      #1;
      check8({7'h00, system_reset}, {7'h00, !c[1]});
      if (!c[1]) wait_run();
    end
    finish_test();
  end
endmodule : testbench
